// *** drive_restart_sequencer.sv ***
`timescale 1ns/1ps
`include "drs_map.svh"
// Summary of operation
// [R1] After coast input release the method comes from the coast restart mode, default zero start.
// [R2] After trip reset release the method comes from the reset restart mode, default zero start.
// [R3] In pull-in mode the output restarts by pull-in once the input is off and the wait expires.
// [R4] The wait time is programmable 0.3 s to 100.0 s in tenths, default 1.0 s.
// [R5] With reset mode pull-in, the first run after power-on also uses pull-in.
// [R6] Reset restart applies to both the reset terminal and the panel stop/reset key.
// [R7] Zero-hertz start applies no wait time.
// [R8] One setting governs both power-on start and reset release restart.
// [R9] A pull-in restart by the reset restart mode keeps the run direction latched when reset was applied.
// [R10] Loss of control supply leads to the reset release method, as power-on does.
// [R11] With panel run source, reset clears the run command and the next start uses reset mode.
// [R12] With panel run source, coast input clears the run command; the next start uses coast mode.
// [R13] With free-run stop method, dropping run coasts and the next run uses coast mode.
// [R14] Run active when coast input falls starts by the coast restart setting.
// [R15] Run active after power-on or reset release starts by the reset restart setting.
// [R16] While coast input is on or the wait runs the output is shut off.
module drive_restart_sequencer #(
  parameter int TENTH_CYC = `DRS_TENTH_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic freeRunStopIn,
  input wire logic tripResetIn,
  input wire logic panelResetKey,
  input wire logic runCmdIn,
  input wire logic runDirIn,
  input wire logic panelRunKey,
  output logic outputEnable,
  output logic startPulse,
  output logic [1:0] startMethod,
  output logic runDir
);
  typedef enum logic [2:0] {ST_IDLE, ST_COAST, ST_WAIT, ST_RUN} drs_state_e;
  drs_state_e state_r, state_nxt;
  logic [15:0] waitTime_r;
  logic [7:0] coastMode_r, resetMode_r, ctrl_r;
  logic [2:0] mbsSync_r, rstSync_r, runSync_r, dirSync_r, panSync_r;
  logic mbs_r, rst_r, run_r, dir_r, panel_r;
  logic useReset_r, panelRun_r, latchDir_r, rstDly_r;
  logic [1:0] pendMethod_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic outEn_r, startP_r;
  logic [1:0] method_r;
  logic runDir_r;
  drs_timer_if tif ();
  drs_wait_timer #(.TENTH_CYC(TENTH_CYC)) uTimer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tif(tif)
  );
  // Three stages; a level change is accepted only when stages two and three agree.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mbsSync_r <= 3'h0;
      rstSync_r <= 3'h0;
      runSync_r <= 3'h0;
      dirSync_r <= 3'h0;
      panSync_r <= 3'h0;
      mbs_r <= 1'b0;
      rst_r <= 1'b0;
      run_r <= 1'b0;
      dir_r <= 1'b0;
      panel_r <= 1'b0;
    end else begin
      mbsSync_r <= {mbsSync_r[1:0], freeRunStopIn};
      rstSync_r <= {rstSync_r[1:0], tripResetIn | panelResetKey}; // R6
      runSync_r <= {runSync_r[1:0], runCmdIn};
      dirSync_r <= {dirSync_r[1:0], runDirIn};
      panSync_r <= {panSync_r[1:0], panelRunKey};
      if (mbsSync_r[1] == mbsSync_r[2]) mbs_r <= mbsSync_r[2];
      if (rstSync_r[1] == rstSync_r[2]) rst_r <= rstSync_r[2];
      if (runSync_r[1] == runSync_r[2]) run_r <= runSync_r[2];
      if (dirSync_r[1] == dirSync_r[2]) dir_r <= dirSync_r[2];
      if (panSync_r[1] == panSync_r[2]) panel_r <= panSync_r[2];
    end
  end
  // APB decode.
  wire setup = psel && !penable;
  wire access = psel && penable && pready_r;
  wire wrEn = access && pwrite;
  wire hitWait = (paddr == `DRS_OFF_WAIT);
  wire hitCoast = (paddr == `DRS_OFF_COAST);
  wire hitReset = (paddr == `DRS_OFF_RESET);
  wire hitCtrl = (paddr == `DRS_OFF_CTRL);
  wire hitStat = (paddr == `DRS_OFF_STATUS);
  wire hitAny = hitWait | hitCoast | hitReset | hitCtrl | hitStat;
  wire [15:0] wrWait = pwdata[15:0];
  wire waitOk = (wrWait >= `DRS_WAIT_MIN) && (wrWait <= `DRS_WAIT_MAX); // R4
  wire modeOk = (pwdata[7:0] <= 8'h03);
  wire badWr = pwrite && ((hitWait && !waitOk) || ((hitCoast || hitReset) && !modeOk));
  wire stopFreeRun = ctrl_r[`DRS_CTRL_STOPSEL];
  wire panelSrc = ctrl_r[`DRS_CTRL_PANEL];
  wire [31:0] statWord = {24'h000000, 1'b0, outEn_r, useReset_r, tif.busy, state_r,
    method_r[0]};
  wire [31:0] rdMux = hitWait ? {16'h0000, waitTime_r} :
    hitCoast ? {24'h000000, coastMode_r} :
    hitReset ? {24'h000000, resetMode_r} :
    hitCtrl ? {24'h000000, ctrl_r} :
    hitStat ? statWord : 32'h00000000;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && (!hitAny || badWr);
      prdata_r <= (setup && !pwrite) ? rdMux : 32'h00000000;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      waitTime_r <= `DRS_WAIT_RST; // R4
      coastMode_r <= `DRS_MODE_RST; // R1
      resetMode_r <= `DRS_MODE_RST; // R2 R8
      ctrl_r <= `DRS_CTRL_RST;
    end else if (wrEn && !pslverr_r) begin
      if (hitWait) waitTime_r <= wrWait;
      if (hitCoast) coastMode_r <= pwdata[7:0];
      if (hitReset) resetMode_r <= pwdata[7:0];
      if (hitCtrl) ctrl_r <= {5'h00, pwdata[2:0]};
    end
  end
  // Panel-sourced run is a latch; reset or coast input clears it.
  wire runActive = panelSrc ? panelRun_r : run_r;
  wire [1:0] coastM = coastMode_r[1:0]; // R1
  wire [1:0] resetM = resetMode_r[1:0]; // R2 R8
  wire [1:0] selM = useReset_r ? resetM : coastM;
  wire needWait = (selM != drs_pkg::START_ZERO); // R7
  wire canStart = runActive && !mbs_r && !rst_r;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (mbs_r) state_nxt = ST_COAST;
        else if (canStart) state_nxt = needWait ? ST_WAIT : ST_RUN; // R7 R15
      ST_COAST: if (!mbs_r) state_nxt = ST_IDLE; // R14 R16
      ST_WAIT: if (mbs_r) state_nxt = ST_COAST;
        else if (!runActive || rst_r) state_nxt = ST_IDLE;
        else if (tif.done) state_nxt = ST_RUN; // R3 R4
      ST_RUN: if (mbs_r) state_nxt = ST_COAST;
        else if (rst_r || !runActive) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end
  assign tif.start = (state_r != ST_WAIT) && (state_nxt == ST_WAIT);
  assign tif.tenths = waitTime_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      useReset_r <= 1'b1; // R5 R10 R15
      panelRun_r <= 1'b0;
      latchDir_r <= 1'b0;
      rstDly_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rstDly_r <= rst_r;
      if (rst_r) useReset_r <= 1'b1; // R2 R6 R11
      else if (mbs_r || (stopFreeRun && state_r == ST_RUN && !runActive)) useReset_r <= 1'b0; // R12 R13
      else if (state_r == ST_RUN && runActive) useReset_r <= 1'b0;
      if (rst_r || mbs_r) panelRun_r <= 1'b0; // R11 R12
      else if (panel_r) panelRun_r <= 1'b1;
      else if (!run_r && panelSrc && state_r == ST_RUN && ctrl_r[`DRS_CTRL_DIR]) panelRun_r <= 1'b0;
      // Capture only at the onset of reset, so later direction changes cannot leak in.
      if (rst_r && !rstDly_r) latchDir_r <= dir_r; // R9
    end
  end
  wire going = (state_nxt == ST_RUN) && (state_r != ST_RUN);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      outEn_r <= 1'b0;
      startP_r <= 1'b0;
      method_r <= 2'h0;
      runDir_r <= 1'b0;
    end else begin
      outEn_r <= (state_nxt == ST_RUN); // R16 R13
      startP_r <= going;
      if (going) method_r <= selM;
      if (going) runDir_r <= (useReset_r && selM == drs_pkg::START_PULLIN) ? latchDir_r : dir_r; // R9
    end
  end
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign outputEnable = outEn_r;
  assign startPulse = startP_r;
  assign startMethod = method_r;
  assign runDir = runDir_r;
  int unsigned stopCnt;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !tif.busy) stopCnt <= 0;
    else stopCnt <= stopCnt + 1;
  end
  coast_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mbs_r |=> ##1 !outputEnable) else $error("Output on while coasting."); // R16
  wait_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tif.busy |-> !outputEnable) else $error("Output on during wait."); // R16
  zero_nowait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (startPulse && startMethod == 2'h0) |-> !$past(tif.busy, 2)) else $error("Zero start waited."); // R7
  pull_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (startPulse && startMethod != 2'h0) |-> $past(tif.done, 1)) else $error("Start skipped wait."); // R3
  wait_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tif.busy |-> stopCnt <= 32'(waitTime_r) * TENTH_CYC) else $error("Wait overrun."); // R4
  wait_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    waitTime_r >= `DRS_WAIT_MIN && waitTime_r <= `DRS_WAIT_MAX) else $error("Wait out of range."); // R4
  reset_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_r |=> useReset_r) else $error("Reset mode not chosen."); // R2
  coast_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mbs_r && !rst_r) |=> !useReset_r) else $error("Coast mode not chosen."); // R1
  panel_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rst_r || mbs_r) |=> !panelRun_r) else $error("Panel run kept."); // R11 R12
  start_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) startPulse);
  pull_cov: cover property (@(posedge clk_sys) disable iff (!rst_n)
    startPulse && startMethod == 2'h2);
  coast_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(mbs_r) && runActive);
  apb_cov: cover property (@(posedge clk_sys) disable iff (!rst_n) pready && pwrite);
endmodule : drive_restart_sequencer

// *** drs_map.svh ***
`ifndef DRS_MAP_SVH
`define DRS_MAP_SVH
`define DRS_OFF_WAIT 12'h000
`define DRS_OFF_COAST 12'h004
`define DRS_OFF_RESET 12'h008
`define DRS_OFF_CTRL 12'h00C
`define DRS_OFF_STATUS 12'h010
`define DRS_WAIT_MIN 16'h0003
`define DRS_WAIT_MAX 16'h03E8
`define DRS_WAIT_RST 16'h000A
`define DRS_MODE_RST 8'h00
`define DRS_CTRL_RST 8'h00
`define DRS_TENTH_NS 100000000
`define DRS_CLK_NS 8
`define DRS_TENTH_CYC (`DRS_TENTH_NS / `DRS_CLK_NS)
`define DRS_CTRL_STOPSEL 0
`define DRS_CTRL_PANEL 1
`define DRS_CTRL_DIR 2
`endif

// *** drs_pkg.sv ***
package drs_pkg;
  typedef enum logic [1:0] {
    START_ZERO,
    START_MATCH,
    START_PULLIN,
    START_ENCODER
  } drs_method_e;
endpackage : drs_pkg

// *** drs_timer_if.sv ***
`timescale 1ns/1ps
interface drs_timer_if;
  logic start;
  logic [15:0] tenths;
  logic busy;
  logic done;
  modport ctrl (output start, output tenths, input busy, input done);
  modport tmr (input start, input tenths, output busy, output done);
endinterface : drs_timer_if

// *** drs_wait_timer.sv ***
`timescale 1ns/1ps
`include "drs_map.svh"
module drs_wait_timer #(
  parameter int TENTH_CYC = `DRS_TENTH_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  drs_timer_if.tmr tif
);
  logic [23:0] divCnt_r;
  logic [15:0] left_r;
  logic busy_r;
  logic done_r;
  wire tick = (divCnt_r == 24'(TENTH_CYC - 1));
  wire lastTick = busy_r && tick && (left_r == 16'h0001);
  assign tif.busy = busy_r;
  assign tif.done = done_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || tif.start || !busy_r || tick) divCnt_r <= 24'h000000;
    else divCnt_r <= divCnt_r + 24'h000001;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      left_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      done_r <= lastTick;
      if (tif.start) begin
        busy_r <= 1'b1;
        left_r <= tif.tenths;
      end else if (busy_r && tick) begin
        left_r <= left_r - 16'h0001;
        if (left_r == 16'h0001) busy_r <= 1'b0;
      end
    end
  end
endmodule : drs_wait_timer

// *** drs_motor_model.sv ***
`timescale 1ns/1ps
// Stands in for the driven motor and records each start that the block launches.
module drs_motor_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic outputEnable,
  input wire logic startPulse,
  input wire logic [1:0] startMethod,
  input wire logic runDir,
  output logic [7:0] starts,
  output logic [1:0] lastMethod,
  output logic lastDir,
  output logic coasting
);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      starts <= 8'h00;
      lastMethod <= 2'h0;
      lastDir <= 1'h0;
    end else if (startPulse) begin
      starts <= starts + 8'h01;
      lastMethod <= startMethod;
      lastDir <= runDir;
    end
  end
  // The motor only idles on its own inertia while the stage is off.
  assign coasting = !outputEnable;
endmodule : drs_motor_model

// *** testbench.sv ***
`timescale 1ns/1ps
`include "drs_map.svh"
module testbench;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic freeRunStopIn, tripResetIn, panelResetKey, runCmdIn, runDirIn, panelRunKey;
  logic outputEnable, startPulse, runDir, lastDir, coasting;
  logic [1:0] startMethod, lastMethod;
  logic [7:0] starts;
  int miscompares = 0;
  int samples_checked = 0;
  // A tenth of a second shrinks to 4 cycles, so the shortest wait is 12 cycles.
  drive_restart_sequencer #(.TENTH_CYC(4)) dut (.clk_sys, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .freeRunStopIn, .tripResetIn,
    .panelResetKey, .runCmdIn, .runDirIn, .panelRunKey, .outputEnable, .startPulse,
    .startMethod, .runDir);
  drs_motor_model mdl (.clk_sys, .rst_n, .outputEnable, .startPulse, .startMethod, .runDir,
    .starts, .lastMethod, .lastDir, .coasting);
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  task end_of_test;
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rdv = prdata;
    chk({pready, pslverr}, {1'h1, err});
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0, 1'h0);
    chk(rdv, e);
  endtask : rd
  // Counts cycles from the caller's edge until the motor model records a start.
  task wstart(input int lo, input int hi, input logic [1:0] m, input logic d);
    int n;
    logic [7:0] s0;
    s0 = starts;
    n = 0;
    while (starts === s0 && n < hi) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n >= lo && n < hi, 1'h1);
    chk({lastMethod, lastDir}, {m, d});
  endtask : wstart
  task quiet(input int n);
    logic [7:0] s0;
    s0 = starts;
    cyc(n);
    chk({starts, coasting}, {s0, 1'h1});
  endtask : quiet
  task press;
    panelRunKey <= 1'h1;
    cyc(4);
    panelRunKey <= 1'h0;
  endtask : press
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    end_of_test;
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {freeRunStopIn, tripResetIn, panelResetKey, runCmdIn, runDirIn, panelRunKey} = 6'h00;
    cyc(3);
    rst_n <= 1'h1;
    rd(`DRS_OFF_WAIT, 32'h0000000A);
    rd(`DRS_OFF_COAST, 32'h0);
    rd(`DRS_OFF_RESET, 32'h0);
    apb(1'h0, 12'h014, 32'h0, 1'h1);
    apb(1'h1, `DRS_OFF_WAIT, 32'h00000002, 1'h1);
    apb(1'h1, `DRS_OFF_WAIT, 32'h000003E9, 1'h1);
    apb(1'h1, `DRS_OFF_WAIT, 32'h00000003, 1'h0);
    rd(`DRS_OFF_WAIT, 32'h00000003);
    apb(1'h1, `DRS_OFF_COAST, 32'h00000004, 1'h1);
    runCmdIn <= 1'h1;
    wstart(0, 12, 2'h0, 1'h0);
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, `DRS_OFF_COAST, 32'(c), 1'h0);
      freeRunStopIn <= 1'h1;
      quiet(8);
      freeRunStopIn <= 1'h0;
      wstart(c ? 12 : 0, c ? 40 : 12, 2'(c), 1'h0);
    end
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, `DRS_OFF_RESET, 32'(c), 1'h0);
      runDirIn <= 1'h1;
      cyc(8);
      if (c[0]) panelResetKey <= 1'h1;
      else tripResetIn <= 1'h1;
      cyc(8);
      runDirIn <= (c != 2);
      cyc(8);
      panelResetKey <= 1'h0;
      tripResetIn <= 1'h0;
      wstart(c ? 12 : 0, c ? 40 : 12, 2'(c), 1'h1);
    end
    runCmdIn <= 1'h0;
    apb(1'h1, `DRS_OFF_CTRL, 32'h00000002, 1'h0);
    apb(1'h1, `DRS_OFF_RESET, 32'h0, 1'h0);
    tripResetIn <= 1'h1;
    cyc(8);
    tripResetIn <= 1'h0;
    cyc(8);
    press;
    wstart(0, 12, 2'h0, 1'h1);
    tripResetIn <= 1'h1;
    cyc(8);
    tripResetIn <= 1'h0;
    quiet(40);
    press;
    wstart(0, 12, 2'h0, 1'h1);
    freeRunStopIn <= 1'h1;
    cyc(8);
    freeRunStopIn <= 1'h0;
    quiet(40);
    press;
    wstart(12, 40, 2'h3, 1'h1);
    runCmdIn <= 1'h1;
    apb(1'h1, `DRS_OFF_CTRL, 32'h00000001, 1'h0);
    cyc(40);
    runCmdIn <= 1'h0;
    quiet(8);
    runCmdIn <= 1'h1;
    wstart(12, 40, 2'h3, 1'h1);
    end_of_test;
  end
endmodule : testbench
